// ### inc/flash_ctrl_pkg.sv
// ====
// Shared constants and types for the flash mode and boot control
package flash_ctrl_pkg;

  // ====
  // Clock and timing
  localparam int CLOCK_MHZ = 25;
  // Quiet time on the mode pin that closes the pulse count
  localparam int SELECT_WINDOW_US = 100;
  localparam int SEL_CNT_W = 12;
  localparam logic [SEL_CNT_W-1:0] SELECT_COUNT =
    SEL_CNT_W'(SELECT_WINDOW_US * CLOCK_MHZ);
  // Edges a pin needs to cross the two-stage synchroniser
  localparam logic [1:0] SETTLE_COUNT = 2'h2;

  // ====
  // Operating mode, one-hot, held from reset release
  typedef enum logic [3:0] {
    MODE_WAIT   = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_PROG   = 4'h4,
    MODE_BAD    = 4'h8
  } mode_e;

  // Programming link chosen by the pulse count, one-hot
  typedef enum logic [4:0] {
    COMM_NONE    = 5'h01,
    COMM_ASYNC   = 5'h02,
    COMM_SYNC    = 5'h04,
    COMM_SYNC_HS = 5'h08,
    COMM_BAD     = 5'h10
  } comm_e;

  localparam int PULSE_W = 4;
  localparam logic [PULSE_W-1:0] PULSES_ASYNC = 4'h0;
  localparam logic [PULSE_W-1:0] PULSES_SYNC = 4'h8;
  localparam logic [PULSE_W-1:0] PULSES_SYNC_HS = 4'hB;
  localparam logic [PULSE_W-1:0] PULSE_MAX = 4'hF;

  // ====
  // Pin map of the shared port pins
  localparam int PIN_COUNT = 12;
  localparam int PIN_TXD = 0;
  localparam int PIN_RXD = 1;
  localparam int PIN_SO = 2;
  localparam int PIN_SI = 3;
  localparam int PIN_SCK = 4;
  localparam int PIN_HS = 5;
  // Reset state of a pin as {oe_n, out}: input, low
  localparam logic [1:0] PIN_RESET_STATE = 2'h2;

  // ====
  // Flash array geometry and boot areas
  localparam int BLOCK_W = 3;
  localparam int SWAP_BIT = 2;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int INFO_W = 8;

  // ====
  // Interrupt redirection while self-programming
  localparam logic [31:0] RAM_START = 32'h0010_0000;
  localparam logic [31:0] NMI_OFFSET = 32'h0000_0000;
  localparam logic [31:0] MASKABLE_OFFSET = 32'h0000_0004;

  // ====
  // Macro service functions
  typedef enum logic [3:0] {
    CMD_INIT        = 4'h0,
    CMD_BLOCK_ERASE = 4'h1,
    CMD_WORD_WRITE  = 4'h2,
    CMD_VERIFY      = 4'h3,
    CMD_BLANK_CHECK = 4'h4,
    CMD_MODE_CHECK  = 4'h5,
    CMD_GET_INFO    = 4'h6,
    CMD_SET_INFO    = 4'h7,
    CMD_BOOT_SWAP   = 4'h8,
    CMD_WORD_READ   = 4'h9
  } cmd_e;

  // Command sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_ISSUE = 3'h2,
    ST_RUN   = 3'h4
  } seq_e;

endpackage : flash_ctrl_pkg

// ### src/flash_block_remap.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Registered logical to physical block map for boot swap
module flash_block_remap (
  input wire logic clock,
  input wire logic reset,
  input wire logic swap,
  input wire logic [flash_ctrl_pkg::BLOCK_W-1:0] logical,
  output logic [flash_ctrl_pkg::BLOCK_W-1:0] physical
);

  logic [flash_ctrl_pkg::BLOCK_W-1:0] next_physical;

  // R09 area exchange
  // Flipping the area bit trades blocks 0-3 with blocks 4-7
  always_comb
  begin
    next_physical = logical;
    next_physical[flash_ctrl_pkg::SWAP_BIT] =
      logical[flash_ctrl_pkg::SWAP_BIT] ^ swap;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      physical <= '0;
    else
      physical <= next_physical;
  end

endmodule : flash_block_remap
`default_nettype wire

// ### src/flash_mode_boot_control.sv
// Overview of operation
// R01 - Mode pin low: normal; high, qualifier low: programming; both high barred
// R02 - Qualifier pin ignored while mode pin is low
// R03 - Programmer holds qualifier low when raising mode pin
// R04 - Self-programming: mode pin is write protect, writes need it high
// R05 - Software keeps mode pin low at reset, raises it only for rewrites
// R06 - Programming mode keeps unused pins in their reset state
// R07 - Async: transmit/receive; sync: out/in/clock; handshake adds its pin
// R08 - Only the programmer drives reset during programming mode
// R09 - Boot swap exchanges blocks 0-3 with blocks 4-7
// R10 - No instruction fetch from flash while self-programming
// R11 - Self-programming vectors: NMI to RAM start, maskable to start plus four
// R12 - Service: init, erase, write, verify, blank, pin check, info, swap, read
// R13 - Mode pins sampled once at reset release, mode held until reset
`timescale 1ns/1ns
`default_nettype none
module flash_mode_boot_control (
  input wire logic clock,
  input wire logic reset,
  input wire logic prog_mode_pin,
  input wire logic mode_qualifier_pin,
  input wire logic [flash_ctrl_pkg::PIN_COUNT-1:0] pin_in,
  input wire logic [flash_ctrl_pkg::PIN_COUNT-1:0] user_pin_out,
  input wire logic [flash_ctrl_pkg::PIN_COUNT-1:0] user_pin_oe_n,
  input wire logic prog_tx,
  input wire logic prog_so,
  input wire logic prog_hs,
  input wire logic self_prog_active,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [flash_ctrl_pkg::BLOCK_W-1:0] cmd_block,
  input wire logic [flash_ctrl_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [flash_ctrl_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic array_done,
  input wire logic array_fail,
  input wire logic [flash_ctrl_pkg::DATA_W-1:0] array_rdata,
  input wire logic [flash_ctrl_pkg::BLOCK_W-1:0] fetch_block,
  input wire logic nmi_take,
  input wire logic int_take,
  input wire logic [31:0] handler_addr,
  output flash_ctrl_pkg::mode_e op_mode,
  output flash_ctrl_pkg::comm_e comm_mode,
  output logic prog_rxd,
  output logic prog_si,
  output logic prog_sck,
  output logic [flash_ctrl_pkg::PIN_COUNT-1:0] pin_out,
  output logic [flash_ctrl_pkg::PIN_COUNT-1:0] pin_oe_n,
  output logic write_allowed,
  output logic fetch_enable,
  output logic [31:0] vector_addr,
  output logic cmd_busy,
  output logic cmd_done,
  output logic cmd_error,
  output logic [flash_ctrl_pkg::DATA_W-1:0] cmd_rdata,
  output logic array_start,
  output flash_ctrl_pkg::cmd_e array_op,
  output logic [flash_ctrl_pkg::BLOCK_W-1:0] array_block,
  output logic [flash_ctrl_pkg::ADDR_W-1:0] array_addr,
  output logic [flash_ctrl_pkg::DATA_W-1:0] array_wdata,
  output logic [flash_ctrl_pkg::BLOCK_W-1:0] fetch_phys_block
);

  // ====
  // Decoding helpers

  // Pin drive as {oe_n, out} for the mode and link in force
  function automatic logic [1:0] pin_drive(
    input flash_ctrl_pkg::mode_e m,
    input flash_ctrl_pkg::comm_e c,
    input int idx,
    input logic uo,
    input logic uoe_n,
    input logic tx,
    input logic so,
    input logic hs
  );
    logic [1:0] r;
    r = flash_ctrl_pkg::PIN_RESET_STATE;
    if (m == flash_ctrl_pkg::MODE_NORMAL)
      r = {uoe_n, uo};
    else if (m == flash_ctrl_pkg::MODE_PROG)
    begin
      // R07 link pin use
      if (idx == flash_ctrl_pkg::PIN_TXD && c == flash_ctrl_pkg::COMM_ASYNC)
        r = {1'b0, tx};
      if (idx == flash_ctrl_pkg::PIN_SO &&
          (c == flash_ctrl_pkg::COMM_SYNC ||
           c == flash_ctrl_pkg::COMM_SYNC_HS))
        r = {1'b0, so};
      if (idx == flash_ctrl_pkg::PIN_HS && c == flash_ctrl_pkg::COMM_SYNC_HS)
        r = {1'b0, hs};
    end
    return r;
  endfunction : pin_drive

  // Functions that alter the flash contents
  function automatic logic writes_flash(input flash_ctrl_pkg::cmd_e c);
    return c == flash_ctrl_pkg::CMD_BLOCK_ERASE ||
           c == flash_ctrl_pkg::CMD_WORD_WRITE ||
           c == flash_ctrl_pkg::CMD_SET_INFO ||
           c == flash_ctrl_pkg::CMD_BOOT_SWAP;
  endfunction : writes_flash

  // Functions handed to the flash array
  function automatic logic is_array_cmd(input flash_ctrl_pkg::cmd_e c);
    return c == flash_ctrl_pkg::CMD_BLOCK_ERASE ||
           c == flash_ctrl_pkg::CMD_WORD_WRITE ||
           c == flash_ctrl_pkg::CMD_VERIFY ||
           c == flash_ctrl_pkg::CMD_BLANK_CHECK ||
           c == flash_ctrl_pkg::CMD_WORD_READ;
  endfunction : is_array_cmd

  // ====
  // Pin synchronisers
  logic mode_meta, mode_sync, qual_meta, qual_sync;
  logic [flash_ctrl_pkg::PIN_COUNT-1:0] pin_meta, pin_sync;

  // Every pin is foreign to this clock; two stages before use
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      qual_meta <= 1'b0;
      qual_sync <= 1'b0;
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      mode_meta <= prog_mode_pin;
      mode_sync <= mode_meta;
      qual_meta <= mode_qualifier_pin;
      qual_sync <= qual_meta;
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ====
  // Mode capture at reset release
  logic [1:0] settle, next_settle;
  flash_ctrl_pkg::mode_e next_op_mode;

  // R13 one-time sample
  // Waits for the synchronisers to fill, then never samples again
  always_comb
  begin
    next_settle = settle;
    next_op_mode = op_mode;
    if (op_mode == flash_ctrl_pkg::MODE_WAIT)
    begin
      if (settle != '0)
        next_settle = settle - 2'h1;
      // R01 R02 mode decode; qualifier only looked at with mode high
      else if (!mode_sync)
        next_op_mode = flash_ctrl_pkg::MODE_NORMAL;
      else if (!qual_sync)
        next_op_mode = flash_ctrl_pkg::MODE_PROG;
      else
        next_op_mode = flash_ctrl_pkg::MODE_BAD;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      settle <= flash_ctrl_pkg::SETTLE_COUNT;
      op_mode <= flash_ctrl_pkg::MODE_WAIT;
    end
    else
    begin
      settle <= next_settle;
      op_mode <= next_op_mode;
    end
  end

  // ====
  // Link selection by mode pin pulses
  logic mode_last, next_mode_last;
  logic [flash_ctrl_pkg::PULSE_W-1:0] pulses, next_pulses;
  logic [flash_ctrl_pkg::SEL_CNT_W-1:0] sel_timer, next_sel_timer;
  flash_ctrl_pkg::comm_e next_comm_mode;

  // Each rising edge restarts the quiet window; expiry fixes the link
  always_comb
  begin
    next_mode_last = mode_sync;
    next_pulses = pulses;
    next_sel_timer = sel_timer;
    next_comm_mode = comm_mode;
    if (op_mode == flash_ctrl_pkg::MODE_PROG &&
        comm_mode == flash_ctrl_pkg::COMM_NONE)
    begin
      if (mode_sync && !mode_last)
      begin
        if (pulses != flash_ctrl_pkg::PULSE_MAX)
          next_pulses = pulses + 4'h1;
        next_sel_timer = flash_ctrl_pkg::SELECT_COUNT;
      end
      else if (sel_timer != '0)
        next_sel_timer = sel_timer - 12'h001;
      else if (pulses == flash_ctrl_pkg::PULSES_ASYNC)
        next_comm_mode = flash_ctrl_pkg::COMM_ASYNC;
      else if (pulses == flash_ctrl_pkg::PULSES_SYNC)
        next_comm_mode = flash_ctrl_pkg::COMM_SYNC;
      else if (pulses == flash_ctrl_pkg::PULSES_SYNC_HS)
        next_comm_mode = flash_ctrl_pkg::COMM_SYNC_HS;
      else
        next_comm_mode = flash_ctrl_pkg::COMM_BAD;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mode_last <= 1'b0;
      pulses <= '0;
      sel_timer <= flash_ctrl_pkg::SELECT_COUNT;
      comm_mode <= flash_ctrl_pkg::COMM_NONE;
    end
    else
    begin
      mode_last <= next_mode_last;
      pulses <= next_pulses;
      sel_timer <= next_sel_timer;
      comm_mode <= next_comm_mode;
    end
  end

  // ====
  // Pin multiplexing and protection outputs
  logic [flash_ctrl_pkg::PIN_COUNT-1:0] next_pin_out, next_pin_oe_n;
  logic next_write_allowed, next_fetch_enable;
  logic [31:0] next_vector_addr;

  // R06 unused pins at reset state; R07 link pins per link
  for (genvar i = 0; i < flash_ctrl_pkg::PIN_COUNT; i++)
  begin : pin_mux
    assign {next_pin_oe_n[i], next_pin_out[i]} =
      pin_drive(op_mode, comm_mode, i, user_pin_out[i], user_pin_oe_n[i],
                prog_tx, prog_so, prog_hs);
  end

  always_comb
  begin
    // R04 write protect; the pin level is live, not the captured one
    next_write_allowed = self_prog_active && mode_sync &&
                         op_mode == flash_ctrl_pkg::MODE_NORMAL;
    // R10 fetch block
    next_fetch_enable = !self_prog_active;
    next_vector_addr = vector_addr;
    // R11 vector redirect; flash handlers are unreachable mid-rewrite
    if (nmi_take)
      next_vector_addr = self_prog_active ?
        flash_ctrl_pkg::RAM_START + flash_ctrl_pkg::NMI_OFFSET : handler_addr;
    else if (int_take)
      next_vector_addr = self_prog_active ?
        flash_ctrl_pkg::RAM_START + flash_ctrl_pkg::MASKABLE_OFFSET :
        handler_addr;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pin_out <= '0;
      pin_oe_n <= '1;
      prog_rxd <= 1'b0;
      prog_si <= 1'b0;
      prog_sck <= 1'b0;
      write_allowed <= 1'b0;
      fetch_enable <= 1'b1;
      vector_addr <= '0;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
      prog_rxd <= pin_sync[flash_ctrl_pkg::PIN_RXD];
      prog_si <= pin_sync[flash_ctrl_pkg::PIN_SI];
      prog_sck <= pin_sync[flash_ctrl_pkg::PIN_SCK];
      write_allowed <= next_write_allowed;
      fetch_enable <= next_fetch_enable;
      vector_addr <= next_vector_addr;
    end
  end

  // ====
  // Macro service sequencer
  flash_ctrl_pkg::seq_e state, next_state;
  flash_ctrl_pkg::cmd_e code, next_array_op;
  logic ready, next_ready, swapped, next_swapped;
  logic [flash_ctrl_pkg::INFO_W-1:0] info, next_info;
  logic [flash_ctrl_pkg::BLOCK_W-1:0] blk, next_blk;
  logic [flash_ctrl_pkg::ADDR_W-1:0] next_array_addr;
  logic [flash_ctrl_pkg::DATA_W-1:0] next_array_wdata, next_cmd_rdata;
  logic next_cmd_done, next_cmd_error, next_array_start;

  assign code = flash_ctrl_pkg::cmd_e'(cmd_code);

  localparam logic [flash_ctrl_pkg::DATA_W-1:0] DATA_W_ZERO = '0;

  // R12 service functions; requests while busy are ignored
  always_comb
  begin
    next_state = state;
    next_array_op = array_op;
    next_ready = ready;
    next_swapped = swapped;
    next_info = info;
    next_blk = blk;
    next_array_addr = array_addr;
    next_array_wdata = array_wdata;
    next_cmd_rdata = cmd_rdata;
    next_cmd_done = 1'b0;
    next_cmd_error = cmd_error;
    next_array_start = 1'b0;
    unique case (state)
      flash_ctrl_pkg::ST_IDLE:
      begin
        if (cmd_valid)
        begin
          next_cmd_done = 1'b1;
          next_cmd_error = 1'b0;
          if (op_mode != flash_ctrl_pkg::MODE_NORMAL || !self_prog_active ||
              (!ready && code != flash_ctrl_pkg::CMD_INIT))
            next_cmd_error = 1'b1;
          // R04 write refusal
          else if (writes_flash(code) && !mode_sync)
            next_cmd_error = 1'b1;
          else if (is_array_cmd(code))
          begin
            next_cmd_done = 1'b0;
            next_array_op = code;
            next_blk = cmd_block;
            next_array_addr = cmd_addr;
            next_array_wdata = cmd_wdata;
            next_state = flash_ctrl_pkg::ST_ISSUE;
          end
          else if (code == flash_ctrl_pkg::CMD_INIT)
            next_ready = 1'b1;
          else if (code == flash_ctrl_pkg::CMD_MODE_CHECK)
            next_cmd_rdata = DATA_W_ZERO | mode_sync;
          else if (code == flash_ctrl_pkg::CMD_GET_INFO)
            next_cmd_rdata = DATA_W_ZERO | {swapped, info};
          else if (code == flash_ctrl_pkg::CMD_SET_INFO)
            next_info = cmd_wdata[flash_ctrl_pkg::INFO_W-1:0];
          // R09 swap request
          else if (code == flash_ctrl_pkg::CMD_BOOT_SWAP)
            next_swapped = !swapped;
          else
            next_cmd_error = 1'b1;
        end
      end
      flash_ctrl_pkg::ST_ISSUE:
      begin
        // Remapped block is registered at this edge, so start is registered with it and both go out next cycle
        next_array_start = 1'b1;
        next_state = flash_ctrl_pkg::ST_RUN;
      end
      flash_ctrl_pkg::ST_RUN:
      begin
        if (array_done)
        begin
          next_cmd_done = 1'b1;
          next_cmd_error = array_fail;
          next_cmd_rdata = array_rdata;
          next_state = flash_ctrl_pkg::ST_IDLE;
        end
      end
      default:
        next_state = flash_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state <= flash_ctrl_pkg::ST_IDLE;
      array_op <= flash_ctrl_pkg::CMD_INIT;
      ready <= 1'b0;
      swapped <= 1'b0;
      info <= '0;
      blk <= '0;
      array_addr <= '0;
      array_wdata <= '0;
      cmd_rdata <= '0;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      cmd_busy <= 1'b0;
      array_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      array_op <= next_array_op;
      ready <= next_ready;
      swapped <= next_swapped;
      info <= next_info;
      blk <= next_blk;
      array_addr <= next_array_addr;
      array_wdata <= next_array_wdata;
      cmd_rdata <= next_cmd_rdata;
      cmd_done <= next_cmd_done;
      cmd_error <= next_cmd_error;
      cmd_busy <= next_state != flash_ctrl_pkg::ST_IDLE;
      array_start <= next_array_start;
    end
  end

  // ====
  // Boot area remapping for array access and instruction fetch

  // R09 area exchange applies to both paths at once
  flash_block_remap array_remap (
    .clock(clock),
    .reset(reset),
    .swap(swapped),
    .logical(blk),
    .physical(array_block)
  );

  flash_block_remap fetch_remap (
    .clock(clock),
    .reset(reset),
    .swap(swapped),
    .logical(fetch_block),
    .physical(fetch_phys_block)
  );

endmodule : flash_mode_boot_control
`default_nettype wire

// ### tb/flash_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Programmer model: mode pins and serial pads
module flash_prog_model (
  input wire logic clock,
  input wire logic frame,
  output logic prog_mode_pin,
  output logic mode_qualifier_pin,
  output logic [2:0] pads
);
  logic [1:0] pat = 2'h0;
  initial prog_mode_pin = 1'b0;
  initial mode_qualifier_pin = 1'b0;
  initial pads = 3'h0;
  task set_pins(input logic level, input logic qual);
    @(posedge clock);
    prog_mode_pin <= level;
    mode_qualifier_pin <= qual;
  endtask : set_pins
  // link pulses, four cycles each so the synchroniser sees them
  task send_pulses(input int count);
    repeat (count)
    begin
      @(posedge clock);
      prog_mode_pin <= 1'b0;
      repeat (4) @(posedge clock);
      prog_mode_pin <= 1'b1;
      repeat (3) @(posedge clock);
    end
  endtask : send_pulses
  // Receive pad changes each cycle, input pad every second cycle; serial clock still outside frames
  always @(posedge clock)
  begin
    pat <= pat + 2'h1;
    pads <= {frame & pat[0], pat[1], ~pat[0]};
  end
endmodule : flash_prog_model
`default_nettype wire

// ### tb/mode_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Port checks for the flash mode and boot control
module mode_ctrl_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic prog_mode_pin,
  input wire logic mode_qualifier_pin,
  input wire logic prog_tx,
  input wire logic prog_so,
  input wire logic prog_hs,
  input wire logic self_prog_active,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic array_done,
  input wire logic array_fail,
  input wire logic [31:0] array_rdata,
  input wire logic nmi_take,
  input wire logic int_take,
  input wire logic [11:0] pin_in,
  input wire logic prog_rxd,
  input wire logic prog_si,
  input wire logic prog_sck,
  input wire flash_ctrl_pkg::mode_e op_mode,
  input wire flash_ctrl_pkg::comm_e comm_mode,
  input wire logic [11:0] pin_out,
  input wire logic [11:0] pin_oe_n,
  input wire logic write_allowed,
  input wire logic fetch_enable,
  input wire logic [31:0] vector_addr,
  input wire logic cmd_busy,
  input wire logic cmd_done,
  input wire logic cmd_error,
  input wire logic [31:0] cmd_rdata,
  input wire logic array_start
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // ====
  // Command steps
  sequence take_array;
    cmd_valid && !cmd_busy && !cmd_done ##1 cmd_busy;
  endsequence
  sequence start_pulse;
    array_start ##1 !array_start;
  endsequence
  sequence bad_take;
    cmd_valid && !cmd_busy && !cmd_done && cmd_code > 4'h9;
  endsequence
  a_mode_capture: assert property (
    $past(op_mode) == flash_ctrl_pkg::MODE_WAIT &&
    op_mode != flash_ctrl_pkg::MODE_WAIT |-> op_mode ==
    (!$past(prog_mode_pin, 3) ? flash_ctrl_pkg::MODE_NORMAL :
    $past(mode_qualifier_pin, 3) ? flash_ctrl_pkg::MODE_BAD :
    flash_ctrl_pkg::MODE_PROG))
    else $error("bad mode capture");
  a_mode_held: assert property (
    $past(op_mode) != flash_ctrl_pkg::MODE_WAIT |-> $stable(op_mode))
    else $error("mode changed after capture");
  a_link_held: assert property (
    comm_mode != flash_ctrl_pkg::COMM_NONE |=> $stable(comm_mode))
    else $error("link changed after choice");
  a_write_guard: assert property (
    (!prog_mode_pin) [*5] |-> !write_allowed)
    else $error("write open with pin low");
  a_fetch_off: assert property (
    self_prog_active |=> !fetch_enable)
    else $error("fetch during rewrite");
  a_ram_vector: assert property (
    self_prog_active && (nmi_take || int_take) |=> vector_addr ==
    flash_ctrl_pkg::RAM_START + ($past(nmi_take) ?
    flash_ctrl_pkg::NMI_OFFSET : flash_ctrl_pkg::MASKABLE_OFFSET))
    else $error("bad RAM vector");
  a_idle_pins: assert property (
    op_mode != flash_ctrl_pkg::MODE_NORMAL |-> pin_oe_n[11:6] == 6'h3F &&
    pin_oe_n[4:3] == 2'h3 && pin_oe_n[1] && pin_out[11:6] == 6'h00 &&
    pin_out[4:3] == 2'h0 && !pin_out[1])
    else $error("unused pad left driven");
  a_txd_async: assert property (
    comm_mode == flash_ctrl_pkg::COMM_ASYNC |=> !pin_oe_n[0] &&
    pin_out[0] == $past(prog_tx) && pin_oe_n[2] && pin_oe_n[5])
    else $error("bad txd pad");
  a_so_sync: assert property (
    comm_mode == flash_ctrl_pkg::COMM_SYNC ||
    comm_mode == flash_ctrl_pkg::COMM_SYNC_HS |=> !pin_oe_n[2] &&
    pin_out[2] == $past(prog_so) && pin_oe_n[0])
    else $error("bad so pad");
  a_hs_pin: assert property (
    comm_mode == flash_ctrl_pkg::COMM_SYNC_HS |=> !pin_oe_n[5] &&
    pin_out[5] == $past(prog_hs))
    else $error("handshake pad wrong");
  a_start_take: assert property (
    take_array |-> ##1 start_pulse)
    else $error("late array start");
  a_array_result: assert property (
    cmd_busy && array_done |=> cmd_done && !cmd_busy &&
    cmd_error == $past(array_fail) && cmd_rdata == $past(array_rdata))
    else $error("array result not returned");
  a_bad_code: assert property (
    bad_take |=> cmd_done && cmd_error)
    else $error("code not refused");
  // pad inputs returned to the engine
  a_pad_return: assert property (
    !$past(reset, 3) |-> prog_rxd == $past(pin_in[1], 3) &&
    prog_si == $past(pin_in[3], 3) && prog_sck == $past(pin_in[4], 3))
    else $error("pad input not returned");
endmodule : mode_ctrl_chk

bind flash_mode_boot_control mode_ctrl_chk chk (.*);
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Self-checking bench for mode and boot control
module tb_top;
  logic clock = 1'b0, reset = 1'b1, frame;
  logic prog_mode_pin, mode_qualifier_pin;
  logic [2:0] pads;
  logic [11:0] pin_in, user_pin_out = 12'h000, user_pin_oe_n = 12'hFFF;
  logic prog_tx = 1'b0, prog_so = 1'b0, prog_hs = 1'b0;
  logic self_prog_active = 1'b0, cmd_valid = 1'b0, array_done = 1'b0;
  logic array_fail = 1'b0, nmi_take = 1'b0, int_take = 1'b0;
  logic [3:0] cmd_code = 4'h0;
  logic [2:0] cmd_block = 3'h0, fetch_block = 3'h0;
  logic [15:0] cmd_addr = 16'h0040;
  logic [31:0] cmd_wdata = 32'hCAFE_0001, array_rdata = 32'h5A5A_0F0F;
  logic [31:0] handler_addr = 32'h0000_0080;
  logic [1:0] wait_cnt = 2'h0;
  int err_total = 0, check_count = 0;
  flash_ctrl_pkg::mode_e op_mode;
  flash_ctrl_pkg::comm_e comm_mode;
  flash_ctrl_pkg::cmd_e array_op;
  logic prog_rxd, prog_si, prog_sck, write_allowed, fetch_enable;
  logic cmd_busy, cmd_done, cmd_error, array_start;
  logic [11:0] pin_out, pin_oe_n;
  logic [31:0] vector_addr, cmd_rdata, array_wdata;
  logic [2:0] array_block, fetch_phys_block;
  logic [15:0] array_addr;
  // Pads: sck, si, rxd from the programmer, the rest held low
  assign pin_in = {7'h00, pads[2], pads[1], 1'b0, pads[0], 1'b0};
  assign frame = (comm_mode != flash_ctrl_pkg::COMM_NONE);
  always #20 clock = ~clock;
  flash_prog_model prog (.*);
  flash_mode_boot_control uut (.*);
  // Flash array answers a few cycles after each start
  always @(posedge clock)
  begin
    array_done <= (wait_cnt == 2'h1);
    if (array_start === 1'b1) wait_cnt <= 2'h3;
    else if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
  end
  // ====
  // Shared tasks
  task end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  // Pins steady across release for the capture
  task do_reset(input logic level, input logic qual);
    prog.set_pins(level, qual);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
  endtask : do_reset
  task settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task issue(input logic [3:0] code, input logic [2:0] blk, input logic bad);
    int n;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_block <= blk;
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1;
    for (n = 0; n < 20 && cmd_done !== 1'b1; n++)
      settle(1);
    if (n == 20)
    begin
      err_total++;
      end_sim;
    end
    check(cmd_error === bad, "command status");
  endtask : issue
  task vec(input logic nmi, input logic [31:0] exp);
    @(posedge clock);
    nmi_take <= nmi;
    int_take <= !nmi;
    @(posedge clock);
    nmi_take <= 1'b0;
    int_take <= 1'b0;
    #1;
    check(vector_addr === exp, "vector");
  endtask : vec
  // ====
  // Scenarios
  task test_normal;
    do_reset(1'b0, 1'b1);
    check(op_mode === flash_ctrl_pkg::MODE_NORMAL, "normal");
    prog.set_pins(1'b1, 1'b1);
    settle(6);
    check(op_mode === flash_ctrl_pkg::MODE_NORMAL, "mode held");
  endtask : test_normal
  // Rewrite with write protect, every service, swap and vectors
  task test_self;
    logic [3:0] c;
    prog.set_pins(1'b0, 1'b0);
    @(posedge clock);
    self_prog_active <= 1'b1;
    settle(6);
    check(fetch_enable === 1'b0, "fetch");
    issue(4'h0, 3'h0, 1'b0);
    issue(4'h1, 3'h1, 1'b1);
    prog.set_pins(1'b1, 1'b0);
    settle(6);
    check(write_allowed === 1'b1, "write open");
    for (c = 4'h0; c < 4'hA; c++)
      issue(c, 3'h1, 1'b0);
    issue(4'hC, 3'h0, 1'b1);
    issue(4'h1, 3'h1, 1'b0);
    check(array_block === 3'h5, "swapped erase");
    check(array_op === flash_ctrl_pkg::CMD_BLOCK_ERASE &&
      array_addr === cmd_addr && array_wdata === cmd_wdata, "ops");
    @(posedge clock);
    fetch_block <= 3'h6;
    array_fail <= 1'b1;
    settle(3);
    check(fetch_phys_block === 3'h2, "swapped fetch");
    issue(4'h3, 3'h2, 1'b1);
    vec(1'b1, flash_ctrl_pkg::RAM_START);
    vec(1'b0, flash_ctrl_pkg::RAM_START +
      flash_ctrl_pkg::MASKABLE_OFFSET);
    self_prog_active <= 1'b0;
    array_fail <= 1'b0;
    vec(1'b1, handler_addr);
    check(fetch_enable === 1'b1, "fetch back");
    prog.set_pins(1'b0, 1'b0);
  endtask : test_self
  // Link choice by pulse count, pad use, later pulses ignored
  task test_links;
    int cnt [4] = '{0, 8, 11, 3};
    logic [4:0] link [4] = '{5'h02, 5'h04, 5'h08, 5'h10};
    logic [11:0] drv [4] = '{12'h001, 12'h004, 12'h024, 12'h000};
    int i, n;
    for (i = 0; i < 4; i++)
    begin
      do_reset(1'b1, 1'b0);
      check(op_mode === flash_ctrl_pkg::MODE_PROG, "prog");
      prog_tx <= 1'b1;
      prog_so <= 1'b1;
      prog_hs <= 1'b1;
      prog.send_pulses(cnt[i]);
      for (n = 0; n < 3000 && comm_mode === flash_ctrl_pkg::COMM_NONE; n++)
        settle(1);
      if (n == 3000)
      begin
        err_total++;
        end_sim;
      end
      settle(3);
      check(comm_mode === link[i], "link");
      check(pin_oe_n === ~drv[i] && pin_out === drv[i], "pads");
      prog.send_pulses(2);
      settle(1);
      check(comm_mode === link[i], "link held");
    end
  endtask : test_links
  task test_bad;
    do_reset(1'b1, 1'b1);
    check(op_mode === flash_ctrl_pkg::MODE_BAD, "prohibited");
    check(pin_oe_n === 12'hFFF && pin_out === 12'h000, "released");
  endtask : test_bad
  initial
  begin
    test_normal;
    test_self;
    test_links;
    test_bad;
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
